/* File: logic/extosc_pkg.sv */
// constants, field layout and state types of the external oscillator control
// Summary of operation
// - valid flag reads 1 only while crystal runs stable, only in modes 11x
// - mode codes 00x keep the external oscillator circuit switched off
// - mode 010 takes a digital CMOS clock straight from the input pin
// - offer CMOS halved, RC, capacitor, crystal and crystal halved modes
// - control bit 3 always reads zero; writes to it are ignored
// - capacitor mode: drive field picks K factor, 0.87 at 000 to 1590 at 111
package extosc_pkg;
   localparam int         ADDR_W        = 12;
   // register indices; byte address is four times the index
   localparam logic [9:0] CTRL_IDX      = 10'h0b1;
   localparam logic [9:0] STAT_IDX      = 10'h0b2;
   localparam logic [9:0] MASK_IDX      = 10'h0b3;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] MASK_ADDR = {MASK_IDX, 2'b00};
   // control register fields
   localparam int         VALID_BIT     = 7;
   localparam int         MODE_LSB      = 4;
   localparam int         DRIVE_LSB     = 0;
   localparam logic [7:0] CTRL_RESET    = 8'h00;
   localparam logic [1:0] IRQ_RESET     = 2'h0;
   // event bits of status and mask
   localparam int         EV_VALID      = 0;
   localparam int         EV_LOST       = 1;
   // mode codes
   localparam logic [2:0] MODE_CMOS     = 3'h2;
   localparam logic [2:0] MODE_CMOS_DIV = 3'h3;
   localparam logic [2:0] MODE_RC       = 3'h4;
   localparam logic [2:0] MODE_CAP      = 3'h5;
   localparam logic [2:0] MODE_XTAL     = 3'h6;
   localparam logic [2:0] MODE_XTAL_DIV = 3'h7;
   // bus answers
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
   // timing
   localparam int         CLK_PERIOD_NS = 25;
   localparam int         STALL_TIME_NS = 100000;
   localparam int         STALL_CYC     =
      (STALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         VALID_EDGES   = 16;
   localparam int         EDGE_W        = 8;
   localparam int         STALL_W       = 16;

   typedef struct packed {
      logic [2:0]         mode;
      logic [2:0]         drive;
      logic               valid;
      logic [1:0]         status;
      logic [1:0]         mask;
      logic               irq;
      logic               osc_d;
      logic               half;
      logic               clk_en;
      logic               osc_on;
      logic [EDGE_W-1:0]  edges;
      logic [STALL_W-1:0] stall;
      logic               awready;
      logic               aw_got;
      logic [ADDR_W-1:0]  awaddr;
      logic               wready;
      logic               w_got;
      logic [7:0]         wdata;
      logic               wstrb0;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               arready;
      logic               rvalid;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
   } extosc_state_t;
endpackage

/* File: logic/extosc_sync.sv */
// two flip-flop synchroniser for levels arriving from outside the clock domain
module extosc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

/* File: logic/extosc_ctrl.sv */
// external oscillator mode control with crystal valid detector and axi4-lite
//
// The AXI4-Lite slave port is this design's own decision.
module extosc_ctrl #(
   parameter int STALL_CYC   = extosc_pkg::STALL_CYC,
   parameter int VALID_EDGES = extosc_pkg::VALID_EDGES
) (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic                          crystal_in_pin,
   output logic                               osc_enable,
   output logic [2:0]                         osc_mode,
   output logic [2:0]                         osc_drive,
   output logic                               osc_clk_en,
   output logic                               irq,
   input  wire logic [extosc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [extosc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready
);
   // elaboration checks on the detector counters
   if (VALID_EDGES < 1 || VALID_EDGES >= (1 << extosc_pkg::EDGE_W)) begin
      $error("VALID_EDGES out of range");
   end
   if (STALL_CYC < 1 || STALL_CYC >= (1 << extosc_pkg::STALL_W)) begin
      $error("STALL_CYC out of range");
   end

   localparam logic [extosc_pkg::EDGE_W-1:0] EDGE_TOP =
      extosc_pkg::EDGE_W'(VALID_EDGES);
   localparam logic [extosc_pkg::STALL_W-1:0] STALL_TOP =
      extosc_pkg::STALL_W'(STALL_CYC);

   extosc_pkg::extosc_state_t s;
   extosc_pkg::extosc_state_t next_s;
   extosc_pkg::extosc_state_t reset_s;
   logic                      osc_sync;
   logic                      rise;
   logic                      is_on;
   logic                      is_xtal;
   logic                      is_div;
   logic                      stat_rd;
   logic [1:0]                events;
   logic [31:0]               ctrl_word;

   // oscillator input crosses into the bus clock domain
   extosc_sync #(
      .WIDTH (1)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (crystal_in_pin),
      .q       (osc_sync)
   );

   // reset value of the whole state
   always_comb begin
      reset_s         = '0;
      reset_s.mode    = extosc_pkg::CTRL_RESET[extosc_pkg::MODE_LSB +: 3];
      reset_s.drive   = extosc_pkg::CTRL_RESET[extosc_pkg::DRIVE_LSB +: 3];
      reset_s.mask    = extosc_pkg::IRQ_RESET;
      reset_s.awready = 1'b1;
      reset_s.wready  = 1'b1;
      reset_s.arready = 1'b1;
   end

   // mode decode and control word as software reads it
   always_comb begin
      is_on   = (s.mode[2:1] != 2'b00);
      is_xtal = (s.mode[2:1] == 2'b11);
      is_div  = (s.mode == extosc_pkg::MODE_CMOS_DIV) ||
                (s.mode == extosc_pkg::MODE_XTAL_DIV);
      rise    = osc_sync & ~s.osc_d;
      ctrl_word = 32'h0;
      ctrl_word[extosc_pkg::VALID_BIT]     = s.valid;
      ctrl_word[extosc_pkg::MODE_LSB +: 3] = s.mode;
      ctrl_word[extosc_pkg::DRIVE_LSB +: 3] = s.drive; // bit 3 stays zero
   end

   // next state of the whole block
   always_comb begin
      next_s        = s;
      next_s.osc_d  = osc_sync;
      next_s.clk_en = 1'b0;
      next_s.osc_on = is_on;
      stat_rd       = 1'b0;
      // clock enable pulse per rising input edge, every second rising edge when halved
      if (!is_on) begin
         next_s.half = 1'b0;
      end else if (rise) begin
         next_s.half   = ~s.half;
         next_s.clk_en = ~is_div | s.half;
      end
      // crystal amplitude detector: a run of edges without a stall
      if (!is_xtal) begin
         next_s.edges = '0;
         next_s.stall = '0;
      end else if (rise) begin
         next_s.stall = '0;
         if (s.edges != EDGE_TOP) begin
            next_s.edges = s.edges + 1'b1;
         end
      end else if (s.stall >= STALL_TOP - 1'b1) begin
         next_s.edges = '0;
         next_s.stall = '0;
      end else begin
         next_s.stall = s.stall + 1'b1;
      end
      next_s.valid = is_xtal && (next_s.edges == EDGE_TOP);
      // write address and data are taken in either order
      if (s_axi_awvalid && s.awready) begin
         next_s.awready = 1'b0;
         next_s.aw_got  = 1'b1;
         next_s.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.wready = 1'b0;
         next_s.w_got  = 1'b1;
         next_s.wdata  = s_axi_wdata[7:0];
         next_s.wstrb0 = s_axi_wstrb[0];
      end
      if (s.aw_got && s.w_got && !s.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = extosc_pkg::RESP_OKAY;
         case (s.awaddr)
            extosc_pkg::CTRL_ADDR: begin
               if (s.wstrb0) begin
                  next_s.mode  = s.wdata[extosc_pkg::MODE_LSB +: 3];
                  next_s.drive = s.wdata[extosc_pkg::DRIVE_LSB +: 3];
               end
            end
            extosc_pkg::MASK_ADDR: begin
               if (s.wstrb0) begin
                  next_s.mask = s.wdata[1:0];
               end
            end
            extosc_pkg::STAT_ADDR: begin
               next_s.bresp = extosc_pkg::RESP_OKAY;
            end
            default: begin
               next_s.bresp = extosc_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid  = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready  = 1'b1;
      end
      // read answers one edge after the address is taken
      if (s_axi_arvalid && s.arready) begin
         next_s.arready = 1'b0;
         next_s.rvalid  = 1'b1;
         next_s.rresp   = extosc_pkg::RESP_OKAY;
         next_s.rdata   = 32'h0;
         case (s_axi_araddr)
            extosc_pkg::CTRL_ADDR: begin
               next_s.rdata = ctrl_word;
            end
            extosc_pkg::STAT_ADDR: begin
               next_s.rdata = {30'h0, s.status};
               stat_rd      = 1'b1;
            end
            extosc_pkg::MASK_ADDR: begin
               next_s.rdata = {30'h0, s.mask};
            end
            default: begin
               next_s.rresp = extosc_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid  = 1'b0;
         next_s.arready = 1'b1;
      end
      // sticky events; a new event beats the clear from the read
      events = 2'b00;
      events[extosc_pkg::EV_VALID] = next_s.valid & ~s.valid;
      events[extosc_pkg::EV_LOST]  = s.valid & ~next_s.valid & is_xtal;
      next_s.status = (stat_rd ? 2'b00 : s.status) | events;
      next_s.irq    = |(next_s.status & next_s.mask);
   end

   // one register for the whole state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= reset_s;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from state flops
   always_comb begin
      osc_enable    = s.osc_on;
      osc_mode      = s.mode;
      osc_drive     = s.drive;
      osc_clk_en    = s.clk_en;
      irq           = s.irq;
      s_axi_awready = s.awready;
      s_axi_wready  = s.wready;
      s_axi_bvalid  = s.bvalid;
      s_axi_bresp   = s.bresp;
      s_axi_arready = s.arready;
      s_axi_rvalid  = s.rvalid;
      s_axi_rdata   = s.rdata;
      s_axi_rresp   = s.rresp;
   end
endmodule

/* File: verification/extosc_xtal_model.sv */
// behavioural crystal on the pin: toggles while running, rests low otherwise
module extosc_xtal_model (
   input  wire logic run,
   output logic      pin
);
   timeunit 1ns;
   timeprecision 100ps;
   // 200 ns period; keeps swinging whatever the drive field says
   initial pin = 1'b0;
   always #100 pin = run ? ~pin : 1'b0;
endmodule

/* File: verification/extosc_ctrl_monitor.sv */
// port-level checker of the external oscillator control block
module extosc_ctrl_monitor #(
   parameter int STALL_CYC   = extosc_pkg::STALL_CYC,
   parameter int VALID_EDGES = extosc_pkg::VALID_EDGES
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        osc_enable,
   input wire logic        osc_clk_en,
   input wire logic [2:0]  osc_mode,
   input wire logic [2:0]  osc_drive,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic [31:0] s_axi_rdata
);
   logic rd_ctrl;
   // remembers whether the read in flight targets the control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_ctrl <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rd_ctrl <= s_axi_araddr == extosc_pkg::CTRL_ADDR;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence aw_w_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   chk_off_mode: assert property (
      (osc_mode[2:1] == 2'b00) [*2] |-> !osc_enable && !osc_clk_en)
      else $error("oscillator active in an off mode");
   chk_on_mode: assert property (
      (osc_mode[2:1] != 2'b00) [*2] |-> osc_enable)
      else $error("oscillator not enabled in an active mode");
   chk_pulse_one: assert property (
      osc_clk_en |=> !osc_clk_en)
      else $error("clock enable longer than one cycle");
   chk_half_gap: assert property (
      osc_clk_en && osc_mode == extosc_pkg::MODE_CMOS_DIV
      |=> !osc_clk_en [*8])
      else $error("halved mode pulses too often");
   chk_bit3_zero: assert property (
      s_axi_rvalid |-> !s_axi_rdata[3])
      else $error("bit 3 read as one");
   chk_valid_mode: assert property (
      s_axi_rvalid && rd_ctrl && s_axi_rdata[6:5] != 2'b11
      |-> !s_axi_rdata[7])
      else $error("valid flag set outside crystal modes");
   chk_fields_out: assert property (
      s_axi_rvalid && rd_ctrl |-> s_axi_rdata[6:4] == osc_mode
      && s_axi_rdata[2:0] == osc_drive)
      else $error("read fields differ from the analog outputs");
   chk_read_answer: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read answer late");
   chk_write_answer: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
endmodule

bind extosc_ctrl extosc_ctrl_monitor #(.STALL_CYC(STALL_CYC),
   .VALID_EDGES(VALID_EDGES)) mon_u (.aclk, .aresetn, .osc_enable,
   .osc_clk_en, .osc_mode, .osc_drive, .s_axi_awvalid, .s_axi_awready,
   .s_axi_bvalid, .s_axi_wvalid, .s_axi_wready, .s_axi_rvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rdata);

/* File: verification/test_external_oscillator_control.sv */
// register-level bench of the external oscillator control block
module test_external_oscillator_control;
   timeunit 1ns;
   timeprecision 100ps;
   logic        aclk, aresetn, pin, run, osc_enable, osc_clk_en, irq;
   logic [2:0]  osc_mode, osc_drive;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          err_total, n_checks, i, k, cnt;
   logic [2:0]  md [3] = '{3'h0, extosc_pkg::MODE_CMOS,
                           extosc_pkg::MODE_CMOS_DIV};
   int          ex [3] = '{0, 20, 10};
   localparam logic [11:0] CA = extosc_pkg::CTRL_ADDR;
   localparam logic [11:0] SA = extosc_pkg::STAT_ADDR;
   localparam logic [11:0] MA = extosc_pkg::MASK_ADDR;
   localparam logic [1:0]  OK = extosc_pkg::RESP_OKAY;

   extosc_ctrl #(.STALL_CYC(40), .VALID_EDGES(4)) dut_u (.aclk, .aresetn,
      .crystal_in_pin(pin), .osc_enable, .osc_mode, .osc_drive, .osc_clk_en,
      .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   extosc_xtal_model xtal_u (.run(run), .pin(pin));

   task automatic conclude;
      if (err_total == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("FAIL %0t got %h expected %h", $time, g, e);
      end
   endtask
   // a wait that ran out of its bound ends the run
   task automatic lim(input int n);
      if (n >= 50) begin
         err_total++;
         $display("FAIL %0t handshake timeout", $time);
         conclude();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] e);
      int n;
      logic aw, w;
      aw = 0;
      w = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (n = 0; n < 50 && !(aw && w); n++) begin
         @(posedge aclk);
         if (s_axi_awready && s_axi_awvalid) begin
            aw = 1;
            s_axi_awvalid <= 0;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            w = 1;
            s_axi_wvalid <= 0;
         end
      end
      lim(n);
      for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) @(posedge aclk);
      lim(n);
      s_axi_bready <= 0;
      chk(s_axi_bresp, e);
      @(posedge aclk);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      int n;
      logic ar;
      ar = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      // hold the address until the edge at which it is taken
      for (n = 0; n < 50 && !ar; n++) begin
         @(posedge aclk);
         if (s_axi_arready && s_axi_arvalid) begin
            ar = 1;
            s_axi_arvalid <= 0;
         end
      end
      lim(n);
      for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) @(posedge aclk);
      lim(n);
      s_axi_rready <= 0;
      chk(s_axi_rdata, d);
      chk(s_axi_rresp, e);
      @(posedge aclk);
   endtask

   // 40 MHz clock
   initial begin
      aclk = 0;
      forever #12.5 aclk = ~aclk;
   end
   // main sequence
   initial begin
      {aresetn, run, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
      s_axi_wdata = 0;
      s_axi_wstrb = 4'hf;
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rc(CA, 0, OK);
      rc(SA, 0, OK);
      rc(MA, 0, OK);
      rc(12'h000, 0, extosc_pkg::RESP_SLVERR);
      wr(12'h000, 8'hff, extosc_pkg::RESP_SLVERR);
      // every mode code, read-only bits written as one
      for (i = 0; i < 8; i++) begin
         wr(CA, {1'b1, i[2:0], 1'b1, ~i[2:0]}, OK);
         rc(CA, {1'b0, i[2:0], 1'b0, ~i[2:0]}, OK);
         chk(osc_enable, i[2:1] != 2'b00);
         chk({osc_mode, osc_drive}, {i[2:0], ~i[2:0]});
      end
      // crystal start-up raises the unmasked interrupt
      wr(MA, 8'h01, OK);
      rc(MA, 8'h01, OK);
      // pins rested low before the oscillator is enabled
      wr(CA, 8'h61, OK);
      run <= 1;
      // settle for 1 ms of 25 ns cycles before trusting the flag
      repeat (40000) @(posedge aclk);
      for (k = 0; k < 400 && irq !== 1'b1; k++) @(posedge aclk);
      lim(k >> 3);
      rc(CA, 8'he1, OK);
      rc(SA, 8'h01, OK);
      repeat (2) @(posedge aclk);
      chk(irq, 0);
      // writes to the status register change nothing
      wr(SA, 8'h03, OK);
      rc(SA, 0, OK);
      wr(CA, 8'he0, OK);
      rc(CA, 8'he0, OK);
      // a write without byte lane 0 leaves the control register alone
      s_axi_wstrb <= 4'he;
      wr(CA, 8'h00, OK);
      s_axi_wstrb <= 4'hf;
      rc(CA, 8'he0, OK);
      // crystal stops with the event masked
      wr(MA, 8'h00, OK);
      run <= 0;
      repeat (80) @(posedge aclk);
      chk(irq, 0);
      rc(SA, 8'h02, OK);
      rc(CA, 8'h60, OK);
      // pulse counts over 20 pin periods: off, plain, halved
      for (i = 0; i < 3; i++) begin
         wr(CA, {1'b0, md[i], 4'h0}, OK);
         run <= 1;
         cnt = 0;
         repeat (160) begin
            @(posedge aclk);
            cnt += osc_clk_en;
         end
         run <= 0;
         chk(cnt > ex[i] - 2 && cnt < ex[i] + 2, 1);
      end
      // reset in mid-run returns every output and register to idle
      aresetn <= 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      chk({osc_enable, osc_mode, osc_drive, osc_clk_en, irq}, 0);
      rc(CA, 0, OK);
      rc(SA, 0, OK);
      rc(MA, 0, OK);
      conclude();
   end
endmodule
